/* File: design/prc_defines.svh */
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define PRC_ADDR_W 5
`define PRC_DATA_W 16
`define PRC_ADDR_RIC 5'h17
`define PRC_ADDR_LED 5'h18
`define PRC_ADDR_XOV 5'h19

// ****************************************
// Reduced interface config fields
// ****************************************
`define PRC_RIC_MODE 5
`define PRC_RIC_OLDREV 4
`define PRC_RIC_OVF 3
`define PRC_RIC_UNF 2
`define PRC_RIC_ELAST_HI 1
`define PRC_RIC_ELAST_LO 0
`define PRC_RIC_ELAST_RST 2'h1
`define PRC_RIC_OLDREV_RST 1'h0

// ****************************************
// LED override fields
// ****************************************
`define PRC_SPEED_INDICATOR_PIN_EN 5
`define PRC_LINK_INDICATOR_PIN_EN 4
`define PRC_LED_ACT_EN 3
`define PRC_SPEED_INDICATOR_PIN_VAL 2
`define PRC_LINK_INDICATOR_PIN_VAL 1
`define PRC_LED_ACT_VAL 0
`define PRC_LED_RST 6'h00

// ****************************************
// Crossover and pause fields
// ****************************************
`define PRC_XOV_AUTO 15
`define PRC_XOV_FORCE 14
`define PRC_XOV_PAUSE_RX 13
`define PRC_ADV_PAUSE 0
`define PRC_ADV_ASYM 1

// ****************************************
// Elasticity tolerance in bits
// ****************************************
`define PRC_TOL_00 5'h0e
`define PRC_TOL_01 5'h02
`define PRC_TOL_10 5'h06
`define PRC_TOL_11 5'h0a
`define PRC_DIBIT_BITS 5'h02

`endif

/* File: design/prc_elastic_mon.sv */
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_elastic_mon (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic pkt_active,
  input wire logic wr_pulse,
  input wire logic [1:0] tol_sel,
  output logic rd_pulse,
  output logic ovf_evt,
  output logic unf_evt
);

  // Tolerance in bits per field code
  function automatic prc_pkg::prc_level_t tol_bits(input logic [1:0] sel);
    unique case (sel)
      2'b00: tol_bits = `PRC_TOL_00;
      2'b01: tol_bits = `PRC_TOL_01;
      2'b10: tol_bits = `PRC_TOL_10;
      2'b11: tol_bits = `PRC_TOL_11;
    endcase
  endfunction

  prc_pkg::prc_eb_state_e state_r, state_nxt;
  prc_pkg::prc_level_t fill_r, fill_nxt;
  wire prc_pkg::prc_level_t tol = tol_bits(tol_sel); // R08
  wire prc_pkg::prc_level_t half = {1'b0, tol[4:1]};
  wire running = (state_r == prc_pkg::PRC_EB_RUN) || (state_r == prc_pkg::PRC_EB_DRAIN);
  wire do_wr = wr_pulse && (state_r != prc_pkg::PRC_EB_IDLE || pkt_active);
  wire prc_pkg::prc_level_t fill_add = do_wr ? `PRC_DIBIT_BITS : 5'h00;
  wire prc_pkg::prc_level_t fill_up = fill_r + fill_add;

  assign rd_pulse = running && (fill_up >= `PRC_DIBIT_BITS);
  // Fill past tolerance or a read with nothing stored
  assign ovf_evt = enable && do_wr && (fill_up > tol); // R19
  assign unf_evt = enable && (state_r == prc_pkg::PRC_EB_RUN) && pkt_active && !rd_pulse; // R19

  always_comb begin
    state_nxt = state_r;
    fill_nxt = rd_pulse ? prc_pkg::prc_level_t'(fill_up - `PRC_DIBIT_BITS) : fill_up;
    if (ovf_evt) begin
      fill_nxt = tol;
    end
    unique case (state_r)
      prc_pkg::PRC_EB_IDLE: if (enable && pkt_active) state_nxt = prc_pkg::PRC_EB_FILL;
      // A short packet that ends before the run level still drains
      prc_pkg::PRC_EB_FILL: begin
        if (!pkt_active) begin
          state_nxt = prc_pkg::PRC_EB_DRAIN;
        end else if (fill_up >= half) begin
          state_nxt = prc_pkg::PRC_EB_RUN;
        end
      end
      prc_pkg::PRC_EB_RUN: if (!pkt_active) state_nxt = prc_pkg::PRC_EB_DRAIN;
      prc_pkg::PRC_EB_DRAIN: if (fill_nxt == 5'h00) state_nxt = prc_pkg::PRC_EB_IDLE;
    endcase
    if (!enable) begin
      state_nxt = prc_pkg::PRC_EB_IDLE;
      fill_nxt = 5'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= prc_pkg::PRC_EB_IDLE;
      fill_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      fill_r <= fill_nxt;
    end
  end

endmodule

/* File: design/prc_pause_resolve.sv */
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_pause_resolve (
  input wire logic [1:0] local_adv,
  input wire logic [1:0] partner_adv,
  input wire logic hcd_full_duplex,
  output logic pause_rx
);

  wire lp = local_adv[`PRC_ADV_PAUSE];
  wire la = local_adv[`PRC_ADV_ASYM];
  wire pp = partner_adv[`PRC_ADV_PAUSE];
  wire pa = partner_adv[`PRC_ADV_ASYM];
  wire sym = lp && pp;
  wire asym_rx = lp && la && !pp && pa;

  // Only valid when the common mode is full duplex
  assign pause_rx = hcd_full_duplex && (sym || asym_rx); // R18

endmodule

/* File: design/prc_pkg.sv */
package prc_pkg;

  typedef logic [15:0] prc_word_t;
  typedef logic [4:0] prc_level_t;

  // Elastic buffer occupancy tracking
  typedef enum logic [1:0] {
    PRC_EB_IDLE = 2'b00,
    PRC_EB_FILL = 2'b01,
    PRC_EB_RUN = 2'b11,
    PRC_EB_DRAIN = 2'b10
  } prc_eb_state_e;

endpackage

/* File: design/prc_regs.sv */
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "prc_defines.svh"

// Function
// R01: Interface config bits 15:6 read zero, writes ignored
// R02: Bit 5 selects standard or reduced MII
// R03: Old-revision bit 0: toggle CRS_DV at end
// R04: Old-revision bit 1: hold CRS_DV, no toggle
// R05: Bit 3 reports receive FIFO overflow
// R06: Bit 2 reports receive FIFO underflow
// R07: Elasticity field bits 1:0, resets to 01
// R08: Field codes map to 14,2,6,10 bit tolerance
// R09: Software halves packet length at 100ppm
// R10: Standard mode bypasses reduced-interface logic
// R11: Speed override bit drives stored speed value
// R12: Link override bit drives stored link value
// R13: Activity override bit drives stored activity value
// R14: LED register reads settings, never pins
// R15: Bit 15 auto crossover enable, strapped reset
// R16: Software disables auto crossover without autoneg
// R17: Force bit swaps transmit and receive pairs
// R18: Bit 13 pause receive from advertisements
// R19: Buffer fill beyond tolerance sets flags
module prc_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic strap_reduced_mode,
  input wire logic strap_auto_crossover,
  input wire logic an_enable,
  input wire logic auto_swap_req,
  input wire logic hcd_full_duplex,
  input wire logic [1:0] local_advert_pause,
  input wire logic [1:0] partner_advert_pause,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic activity,
  input wire logic rx_crs,
  input wire logic rx_dv,
  input wire logic [3:0] rx_nibble,
  input wire logic [1:0] rec_dibit,
  input wire logic rec_valid,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_crs,
  output logic [1:0] rmii_rxd,
  output logic rmii_crs_dv,
  output logic speed_indicator_pin,
  output logic link_indicator_pin,
  output logic activity_collision_pin,
  output logic pair_swap,
  output logic pause_rx_enable
);

  // ****************************************
  // Address decode
  // ****************************************
  wire sel_ric = (reg_addr == `PRC_ADDR_RIC);
  wire sel_led = (reg_addr == `PRC_ADDR_LED);
  wire sel_xov = (reg_addr == `PRC_ADDR_XOV);
  wire wr_ric = reg_wr && sel_ric;
  wire wr_led = reg_wr && sel_led;
  wire wr_xov = reg_wr && sel_xov;
  wire rd_ric = reg_rd && sel_ric;

  // ****************************************
  // Register state
  // ****************************************
  logic strap_pend_r;
  logic reduced_mode_r, reduced_mode_nxt;
  logic reduced_if_old_revision_r, reduced_if_old_revision_nxt;
  logic rx_fifo_overflow_flag_r, rx_fifo_overflow_flag_nxt;
  logic rx_fifo_underflow_flag_r, rx_fifo_underflow_flag_nxt;
  logic [1:0] elasticity_tolerance_r, elasticity_tolerance_nxt;
  logic [5:0] led_ctl_r, led_ctl_nxt;
  logic auto_crossover_enable_r, auto_crossover_enable_nxt;
  logic forced_pair_swap_r, forced_pair_swap_nxt;
  logic pause_rx_r;
  prc_pkg::prc_word_t rdata_r, rdata_nxt;

  wire speed_led_override_en = led_ctl_r[`PRC_SPEED_INDICATOR_PIN_EN];
  wire link_led_override_en = led_ctl_r[`PRC_LINK_INDICATOR_PIN_EN];
  wire activity_led_override_en = led_ctl_r[`PRC_LED_ACT_EN];
  wire speed_led_forced_value = led_ctl_r[`PRC_SPEED_INDICATOR_PIN_VAL];
  wire link_led_forced_value = led_ctl_r[`PRC_LINK_INDICATOR_PIN_VAL];
  wire activity_led_forced_value = led_ctl_r[`PRC_LED_ACT_VAL];

  // ****************************************
  // Elasticity monitor and pause resolution
  // ****************************************
  wire pkt_active = rx_crs || rx_dv;
  logic eb_rd;
  logic eb_ovf;
  logic eb_unf;
  logic pause_rx_res;

  prc_elastic_mon u_elastic (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(reduced_mode_r),
    .pkt_active(pkt_active),
    .wr_pulse(rec_valid),
    .tol_sel(elasticity_tolerance_r),
    .rd_pulse(eb_rd),
    .ovf_evt(eb_ovf),
    .unf_evt(eb_unf)
  );

  prc_pause_resolve u_pause (
    .local_adv(local_advert_pause),
    .partner_adv(partner_advert_pause),
    .hcd_full_duplex(hcd_full_duplex),
    .pause_rx(pause_rx_res)
  );

  // ****************************************
  // Next-state for writable fields
  // ****************************************
  // Straps load once at the first edge after release
  assign reduced_mode_nxt = strap_pend_r ? strap_reduced_mode
                          : wr_ric ? reg_wdata[`PRC_RIC_MODE] : reduced_mode_r; // R02
  assign reduced_if_old_revision_nxt = wr_ric ? reg_wdata[`PRC_RIC_OLDREV]
                                     : reduced_if_old_revision_r;
  assign elasticity_tolerance_nxt = wr_ric ? reg_wdata[`PRC_RIC_ELAST_HI:`PRC_RIC_ELAST_LO]
                                  : elasticity_tolerance_r; // R07
  assign led_ctl_nxt = wr_led ? reg_wdata[`PRC_SPEED_INDICATOR_PIN_EN:`PRC_LED_ACT_VAL] : led_ctl_r;
  assign auto_crossover_enable_nxt = strap_pend_r ? strap_auto_crossover
                                   : wr_xov ? reg_wdata[`PRC_XOV_AUTO] : auto_crossover_enable_r; // R15
  assign forced_pair_swap_nxt = wr_xov ? reg_wdata[`PRC_XOV_FORCE] : forced_pair_swap_r;

  // ****************************************
  // Status flags: sticky, cleared by reading, set wins
  // ****************************************
  assign rx_fifo_overflow_flag_nxt = eb_ovf || (rx_fifo_overflow_flag_r && !rd_ric); // R05
  assign rx_fifo_underflow_flag_nxt = eb_unf || (rx_fifo_underflow_flag_r && !rd_ric); // R06

  // ****************************************
  // Read mux
  // ****************************************
  wire prc_pkg::prc_word_t ric_view = {10'h000, // R01
                                       reduced_mode_r,
                                       reduced_if_old_revision_r,
                                       rx_fifo_overflow_flag_r,
                                       rx_fifo_underflow_flag_r,
                                       elasticity_tolerance_r};
  // Stored settings only, pin levels are not visible
  wire prc_pkg::prc_word_t led_view = {10'h000, led_ctl_r}; // R14
  wire prc_pkg::prc_word_t xov_view = {auto_crossover_enable_r,
                                       forced_pair_swap_r,
                                       pause_rx_r,
                                       13'h0000};

  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      if (sel_ric) begin
        rdata_nxt = ric_view;
      end else if (sel_led) begin
        rdata_nxt = led_view;
      end else if (sel_xov) begin
        rdata_nxt = xov_view;
      end
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_pend_r <= 1'b1;
      reduced_mode_r <= 1'b0;
      reduced_if_old_revision_r <= `PRC_RIC_OLDREV_RST;
      elasticity_tolerance_r <= `PRC_RIC_ELAST_RST;
      rx_fifo_overflow_flag_r <= 1'b0;
      rx_fifo_underflow_flag_r <= 1'b0;
    end else begin
      strap_pend_r <= 1'b0;
      reduced_mode_r <= reduced_mode_nxt;
      reduced_if_old_revision_r <= reduced_if_old_revision_nxt;
      elasticity_tolerance_r <= elasticity_tolerance_nxt;
      rx_fifo_overflow_flag_r <= rx_fifo_overflow_flag_nxt;
      rx_fifo_underflow_flag_r <= rx_fifo_underflow_flag_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      led_ctl_r <= `PRC_LED_RST;
      auto_crossover_enable_r <= 1'b0;
      forced_pair_swap_r <= 1'b0;
      pause_rx_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      led_ctl_r <= led_ctl_nxt;
      auto_crossover_enable_r <= auto_crossover_enable_nxt;
      forced_pair_swap_r <= forced_pair_swap_nxt;
      pause_rx_r <= pause_rx_res; // R18
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // LED outputs
  // ****************************************
  wire spd_led_nxt = speed_led_override_en ? speed_led_forced_value : speed_100; // R11
  wire lnk_led_nxt = link_led_override_en ? link_led_forced_value : link_up; // R12
  wire act_led_nxt = activity_led_override_en ? activity_led_forced_value : activity; // R13

  // ****************************************
  // Pair selection
  // ****************************************
  // Auto crossover acts only under autoneg, even if software leaves it set
  wire auto_swap = auto_crossover_enable_r && an_enable && auto_swap_req; // R16
  wire swap_nxt = forced_pair_swap_r || auto_swap; // R17

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      speed_indicator_pin <= 1'b0;
      link_indicator_pin <= 1'b0;
      activity_collision_pin <= 1'b0;
      pair_swap <= 1'b0;
    end else begin
      speed_indicator_pin <= spd_led_nxt;
      link_indicator_pin <= lnk_led_nxt;
      activity_collision_pin <= act_led_nxt;
      pair_swap <= swap_nxt;
    end
  end

  assign pause_rx_enable = pause_rx_r;

  // ****************************************
  // Receive path
  // ****************************************
  logic crs_dv_r, crs_dv_nxt;
  logic [1:0] rmii_rxd_r;
  logic [3:0] mii_rxd_r;
  logic mii_dv_r;
  logic mii_crs_r;

  // Old revision keeps CRS_DV high while data remains
  wire crs_dv_tail = reduced_if_old_revision_r ? 1'b1 // R04
                   : !crs_dv_r; // R03
  always_comb begin
    crs_dv_nxt = 1'b0;
    if (reduced_mode_r) begin
      if (rx_crs) begin
        crs_dv_nxt = 1'b1;
      end else if (rx_dv) begin
        crs_dv_nxt = crs_dv_tail;
      end
    end
  end

  // Standard mode feeds MII, reduced path held idle
  wire std_path = !reduced_mode_r; // R10
  wire [3:0] mii_rxd_nxt = std_path ? rx_nibble : 4'h0;
  wire mii_dv_nxt = std_path && rx_dv;
  wire mii_crs_nxt = std_path && rx_crs;
  wire [1:0] rmii_rxd_nxt = (reduced_mode_r && eb_rd) ? rec_dibit : 2'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      crs_dv_r <= 1'b0;
      rmii_rxd_r <= 2'h0;
      mii_rxd_r <= 4'h0;
      mii_dv_r <= 1'b0;
      mii_crs_r <= 1'b0;
    end else begin
      crs_dv_r <= crs_dv_nxt;
      rmii_rxd_r <= rmii_rxd_nxt;
      mii_rxd_r <= mii_rxd_nxt;
      mii_dv_r <= mii_dv_nxt;
      mii_crs_r <= mii_crs_nxt;
    end
  end

  assign rmii_crs_dv = crs_dv_r;
  assign rmii_rxd = rmii_rxd_r;
  assign mii_rxd = mii_rxd_r;
  assign mii_rx_dv = mii_dv_r;
  assign mii_crs = mii_crs_r;

endmodule

/* File: tb/prc_mac_model.sv */
`timescale 1ns/1ps
// ****************
// Receiving MAC
// ****************
module prc_mac_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rmii_crs_dv,
  output logic [7:0] dv_edges
);
  logic dv_last_r;
  // Counts every carrier/valid edge, so a toggling tail shows as extra edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dv_last_r <= 1'b0;
      dv_edges <= 8'h00;
    end else begin
      dv_last_r <= rmii_crs_dv;
      if (dv_last_r != rmii_crs_dv) begin
        dv_edges <= dv_edges + 8'h01;
      end
    end
  end
endmodule

/* File: tb/prc_regs_asserts.sv */
`timescale 1ns/1ps
// ****************
// Register block checks
// ****************
module prc_regs_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic hcd_full_duplex,
  input wire logic [1:0] local_advert_pause,
  input wire logic [1:0] partner_advert_pause,
  input wire logic mii_rx_dv,
  input wire logic mii_crs,
  input wire logic [1:0] rmii_rxd,
  input wire logic rmii_crs_dv,
  input wire logic speed_indicator_pin,
  input wire logic link_indicator_pin,
  input wire logic pair_swap,
  input wire logic pause_rx_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire ric_wr = reg_wr && reg_addr == 5'h17;
  wire led_wr = reg_wr && reg_addr == 5'h18;
  wire xov_wr = reg_wr && reg_addr == 5'h19;
  property p_ric_rsvd;
    reg_rd && reg_addr == 5'h17 |=> reg_rdata[15:6] == 10'h000;
  endproperty
  a_ric_rsvd: assert property (p_ric_rsvd) else $error("reserved bits set");
  property p_led_read;
    led_wr ##1 !led_wr ##1 (reg_rd && reg_addr == 5'h18) |=> reg_rdata == {10'h000, $past(reg_wdata[5:0], 3)};
  endproperty
  a_led_read: assert property (p_led_read) else $error("led readback wrong");
  property p_bypass;
    rmii_crs_dv |-> !mii_rx_dv && !mii_crs;
  endproperty
  a_bypass: assert property (p_bypass) else $error("both paths active");
  property p_std_quiet;
    ric_wr && !reg_wdata[5] ##1 !ric_wr |=> !rmii_crs_dv && rmii_rxd == 2'h0;
  endproperty
  a_std_quiet: assert property (p_std_quiet) else $error("reduced path active");
  property p_pause_on;
    (hcd_full_duplex && local_advert_pause == 2'h1 && partner_advert_pause == 2'h1) [*2] |-> pause_rx_enable;
  endproperty
  a_pause_on: assert property (p_pause_on) else $error("pause not set");
  property p_pause_off;
    (!hcd_full_duplex) [*2] |-> !pause_rx_enable;
  endproperty
  a_pause_off: assert property (p_pause_off) else $error("pause without duplex");
  property p_spd_force;
    led_wr && reg_wdata[5] ##1 !led_wr |=> speed_indicator_pin == $past(reg_wdata[2], 2);
  endproperty
  a_spd_force: assert property (p_spd_force) else $error("speed pin not forced");
  property p_lnk_force;
    led_wr && reg_wdata[4] ##1 !led_wr |=> link_indicator_pin == $past(reg_wdata[1], 2);
  endproperty
  a_lnk_force: assert property (p_lnk_force) else $error("link pin not forced");
  property p_force_swap;
    xov_wr && reg_wdata[14] ##1 !xov_wr |=> pair_swap;
  endproperty
  a_force_swap: assert property (p_force_swap) else $error("pairs not swapped");
  c_led: cover property (led_wr ##2 speed_indicator_pin);
  c_tog: cover property (rmii_crs_dv ##1 !rmii_crs_dv ##1 rmii_crs_dv);
  c_pause: cover property (pause_rx_enable);
endmodule
bind prc_regs prc_regs_asserts chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hcd_full_duplex(hcd_full_duplex), .mii_crs(mii_crs),
  .local_advert_pause(local_advert_pause), .partner_advert_pause(partner_advert_pause),
  .mii_rx_dv(mii_rx_dv), .rmii_rxd(rmii_rxd), .rmii_crs_dv(rmii_crs_dv), .pair_swap(pair_swap),
  .speed_indicator_pin(speed_indicator_pin), .link_indicator_pin(link_indicator_pin),
  .pause_rx_enable(pause_rx_enable)
);

/* File: tb/tb.sv */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tb;
  logic sys_clk, resetn, reg_wr, reg_rd, strap_reduced_mode, strap_auto_crossover, an_enable;
  logic auto_swap_req, hcd_full_duplex, link_up, speed_100, activity, rx_crs, rx_dv, rec_valid;
  logic mii_rx_dv, mii_crs, rmii_crs_dv, speed_indicator_pin, link_indicator_pin;
  logic activity_collision_pin, pair_swap, pause_rx_enable;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0] local_advert_pause, partner_advert_pause, rec_dibit, rmii_rxd;
  logic [3:0] rx_nibble, mii_rxd;
  logic [7:0] dv_edges, e0, d;
  int miscompares = 0;
  int cmp_count = 0;
  logic [36:0] rows [0:8] = '{
    {5'h17, 16'hffff, 16'h0033}, {5'h17, 16'h0001, 16'h0001}, {5'h17, 16'h0002, 16'h0002},
    {5'h17, 16'h0000, 16'h0000}, {5'h18, 16'hffff, 16'h003f}, {5'h18, 16'hffc0, 16'h0000},
    {5'h19, 16'hffff, 16'hc000}, {5'h19, 16'h0000, 16'h0000}, {5'h1a, 16'hffff, 16'h0000}};
  prc_regs dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_reduced_mode(strap_reduced_mode),
    .strap_auto_crossover(strap_auto_crossover), .an_enable(an_enable), .auto_swap_req(auto_swap_req),
    .hcd_full_duplex(hcd_full_duplex), .local_advert_pause(local_advert_pause),
    .partner_advert_pause(partner_advert_pause), .link_up(link_up), .speed_100(speed_100),
    .activity(activity), .rx_crs(rx_crs), .rx_dv(rx_dv), .rx_nibble(rx_nibble), .rec_dibit(rec_dibit),
    .rec_valid(rec_valid), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .mii_crs(mii_crs),
    .rmii_rxd(rmii_rxd), .rmii_crs_dv(rmii_crs_dv), .speed_indicator_pin(speed_indicator_pin),
    .link_indicator_pin(link_indicator_pin), .activity_collision_pin(activity_collision_pin),
    .pair_swap(pair_swap), .pause_rx_enable(pause_rx_enable)
  );
  prc_mac_model mac_u (.sys_clk(sys_clk), .resetn(resetn), .rmii_crs_dv(rmii_crs_dv), .dv_edges(dv_edges));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One packet of nw dibits, carrier held, then a data-valid-only tail
  // A one-dibit packet stays inside every tolerance; two dibits overflow the 2-bit one
  task pkt(input int nw);
    e0 = dv_edges;
    @(posedge sys_clk);
    rx_crs <= 1'b1;
    rec_valid <= 1'b1;
    repeat (nw) @(posedge sys_clk);
    rec_valid <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rx_crs <= 1'b0;
    rx_dv <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rx_dv <= 1'b0;
    tick(4);
    d = dv_edges - e0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    results();
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, an_enable, auto_swap_req, hcd_full_duplex} = '0;
    {local_advert_pause, partner_advert_pause, rx_crs, rx_dv, rec_valid} = '0;
    rec_dibit = 2'h3;
    {link_up, speed_100, activity, strap_reduced_mode, strap_auto_crossover} = 5'h0f;
    rx_nibble = 4'h5;
    resetn = 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(5'h17);
    chk("ric_rst", rd_val, 16'h0021);
    rd(5'h18);
    chk("led_rst", rd_val, 16'h0000);
    rd(5'h19);
    chk("xov_rst", rd_val, 16'h8000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i][36:32], rows[i][31:16]);
      rd(rows[i][36:32]);
      chk("row", rd_val, rows[i][15:0]);
    end
    $display("test rows done");
    wr(5'h18, 16'h003a);
    tick(1);
    chk("led_frc", {13'h0, speed_indicator_pin, link_indicator_pin, activity_collision_pin}, 16'h0002);
    wr(5'h18, 16'h0000);
    tick(1);
    chk("led_norm", {13'h0, speed_indicator_pin, link_indicator_pin, activity_collision_pin}, 16'h0005);
    $display("test led done");
    wr(5'h19, 16'h8000);
    an_enable <= 1'b1;
    auto_swap_req <= 1'b1;
    tick(2);
    chk("auto_swap", {15'h0, pair_swap}, 16'h0001);
    @(posedge sys_clk);
    an_enable <= 1'b0;
    tick(2);
    chk("auto_off", {15'h0, pair_swap}, 16'h0000);
    wr(5'h19, 16'h0000);
    $display("test xover done");
    @(posedge sys_clk);
    {local_advert_pause, partner_advert_pause, hcd_full_duplex} <= 5'h0b;
    tick(2);
    rd(5'h19);
    chk("pause_reg", rd_val, 16'h2000);
    chk("pause_pin", {15'h0, pause_rx_enable}, 16'h0001);
    @(posedge sys_clk);
    hcd_full_duplex <= 1'b0;
    tick(2);
    chk("pause_hd", {15'h0, pause_rx_enable}, 16'h0000);
    $display("test pause done");
    wr(5'h17, 16'h0021);
    pkt(1);
    chk("toggle", {15'h0, d > 8'h02}, 16'h0001);
    rd(5'h17);
    chk("unf", {15'h0, rd_val[2]}, 16'h0001);
    rd(5'h17);
    chk("unf_clr", {15'h0, rd_val[2]}, 16'h0000);
    wr(5'h17, 16'h0031);
    pkt(1);
    chk("hold", {8'h0, d}, 16'h0002);
    wr(5'h17, 16'h0001);
    pkt(1);
    chk("bypass", {8'h0, d}, 16'h0000);
    @(posedge sys_clk);
    rx_dv <= 1'b1;
    tick(2);
    chk("mii", {10'h0, mii_crs, mii_rx_dv, mii_rxd}, 16'h0015);
    @(posedge sys_clk);
    rx_dv <= 1'b0;
    wr(5'h17, 16'h0021);
    pkt(2);
    rd(5'h17);
    chk("ovf", {15'h0, rd_val[3]}, 16'h0001);
    wr(5'h17, 16'h0020);
    pkt(2);
    rd(5'h17);
    chk("no_ovf", {15'h0, rd_val[3]}, 16'h0000);
    $display("test receive done");
    @(posedge sys_clk);
    strap_reduced_mode <= 1'b0;
    resetn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(5'h17);
    chk("ric_rst2", rd_val, 16'h0001);
    $display("test reset again done");
    results();
  end
endmodule
